/* design/wdt_core.sv */
//
// Function
// - Watchdog asserts system reset when active counter expires unreloaded.
// - Software option: watchdog stays inactive until activation bit set.
// - Once active, writes cannot deactivate; only reset does.
// - Inactive under software option, STOP halts the oscillator.
// - Hardware option: watchdog active always from reset onward.
// - Hardware option: STOP acts as WAIT, oscillator and counter keep running.
// - After leaving STOP, counting resumes from the held value.
// - Reset loads register with FEh: inactive, soft-reset and count bits set.
// - Soft-reset bit falling one to zero triggers reset.
// - Count bits reversed: register bit 7 is count_lsb, bit 2 count_msb.
// - Timeout selectable among 64 periods, 3072 to 196608 cycles.
// - Register sits at data-space address D8h, read and write.
// - Counter clock is internal clock divided by twelve.
// - Hardware option: activation bit reads one, writes ignored.
// - Inactive counter is a free seven-bit timer causing no reset.
//
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_core
	import wdt_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       hw_option,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic       stop_req,
	input  wire logic       wait_req,
	input  wire logic       wake_irq,
	output logic      [7:0] rdata_r,
	output logic            sys_rst_r,
	output logic            osc_halt_r,
	output logic            cpu_wait_r
);

	////////////////////////////////////////////////////////////////////////
	// Decode and prescaler

	wdt_cnt_t   cnt_r;
	wdt_cnt_t   cnt_nxt;
	logic       active_r;
	logic       active;
	logic       wr_hit;
	logic       rd_hit;
	logic       step;
	logic [7:0] reg_view;
	pmode_t     pm_r;
	pmode_t     pm_nxt;

	wdt_tick_if tk ();

	assign wr_hit = wr_en && (addr == `WDT_REG_ADDR);
	assign rd_hit = rd_en && (addr == `WDT_REG_ADDR);
	assign active = hw_option || active_r;
	assign step   = tk.step;
	assign tk.run = (pm_nxt != PM_STOP);

	wdt_prescaler #(
		.DIV   (`WDT_CLK_DIV),
		.TICKS (`WDT_STEP_TICKS)
	) u_prescaler (
		.mclk (mclk),
		.nrst (nrst),
		.tk   (tk)
	);

	////////////////////////////////////////////////////////////////////////
	// Register view, count bits reversed

	always_comb begin
		reg_view = 8'h00;
		reg_view[`WDT_BIT_ACTIVATE] = active;
		reg_view[`WDT_BIT_SOFT_RST] = cnt_r[6];
		for (int i = 0; i < 6; i++) begin
			reg_view[`WDT_CNT_HI_BIT - i] = cnt_r[i];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (rd_hit) begin
			rdata_r <= reg_view;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Activation bit

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			active_r <= 1'b0;
		end else if (wr_hit && wdata[`WDT_BIT_ACTIVATE] && !hw_option) begin
			active_r <= 1'b1;
		end else begin
			active_r <= active_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Downcounter

	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_hit) begin
			cnt_nxt[6] = wdata[`WDT_BIT_SOFT_RST];
			for (int i = 0; i < 6; i++) begin
				cnt_nxt[i] = wdata[`WDT_CNT_HI_BIT - i];
			end
		end else if (step) begin
			cnt_nxt = cnt_r - 7'h01;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= `WDT_CNT_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset request, held until the system reset arrives

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sys_rst_r <= 1'b0;
		end else if (wr_hit && cnt_r[6] && !wdata[`WDT_BIT_SOFT_RST]) begin
			sys_rst_r <= 1'b1;
		end else if (active && !wr_hit && step
				&& cnt_r == `WDT_CNT_EDGE) begin
			sys_rst_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power mode

	always_comb begin
		pm_nxt = pm_r;
		unique case (pm_r)
			PM_RUN: begin
				if (stop_req && !active) begin
					pm_nxt = PM_STOP;
				end else if (stop_req || wait_req) begin
					pm_nxt = PM_WAIT;
				end
			end
			PM_WAIT: begin
				if (wake_irq) begin
					pm_nxt = PM_RUN;
				end
			end
			PM_STOP: begin
				if (wake_irq) begin
					pm_nxt = PM_RUN;
				end
			end
			default: pm_nxt = PM_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pm_r <= PM_RUN;
		end else begin
			pm_r <= pm_nxt;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			osc_halt_r <= 1'b0;
			cpu_wait_r <= 1'b0;
		end else begin
			osc_halt_r <= (pm_nxt == PM_STOP);
			cpu_wait_r <= (pm_nxt == PM_WAIT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic seen_r;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= 1'b1;
		end
	end

	sequence s_expire;
		active && !wr_hit && step && (cnt_r == 7'h40);
	endsequence

	sequence s_sr_clear;
		wr_hit && cnt_r[6] && !wdata[`WDT_BIT_SOFT_RST];
	endsequence

	property p_expire;
		@(posedge mclk) disable iff (!nrst)
		s_expire |=> sys_rst_r && (cnt_r == 7'h3F);
	endproperty
	a_expire: assert property (p_expire)
		else $error("expiry gave no reset");

	property p_sr_clear;
		@(posedge mclk) disable iff (!nrst)
		s_sr_clear |=> sys_rst_r ##1 sys_rst_r;
	endproperty
	a_sr_clear: assert property (p_sr_clear)
		else $error("soft-reset clear gave no reset");

	property p_stays_off;
		@(posedge mclk) disable iff (!nrst)
		!hw_option && !active && !(wr_hit && wdata[0]) |=> !active;
	endproperty
	a_stays_off: assert property (p_stays_off)
		else $error("watchdog woke by itself");

	property p_sticky;
		@(posedge mclk) disable iff (!nrst)
		active_r |=> active_r [*2];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("watchdog was deactivated");

	property p_hw_on;
		@(posedge mclk) disable iff (!nrst)
		hw_option && rd_hit |=> rdata_r[0];
	endproperty
	a_hw_on: assert property (p_hw_on)
		else $error("activation bit not forced");

	property p_stop_halt;
		@(posedge mclk) disable iff (!nrst)
		(pm_r == PM_RUN) && stop_req && !active |=> osc_halt_r;
	endproperty
	a_stop_halt: assert property (p_stop_halt)
		else $error("stop did not halt oscillator");

	property p_stop_wait;
		@(posedge mclk) disable iff (!nrst)
		(pm_r == PM_RUN) && stop_req && hw_option |=> cpu_wait_r && !osc_halt_r;
	endproperty
	a_stop_wait: assert property (p_stop_wait)
		else $error("stop not taken as wait");

	property p_freeze;
		@(posedge mclk) disable iff (!nrst)
		(pm_r == PM_STOP) && !wr_hit |=> $stable(cnt_r);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("counter moved in stop");

	property p_reset_val;
		@(posedge mclk) disable iff (!nrst)
		!seen_r |-> (cnt_r == `WDT_CNT_RESET) && !active_r && !sys_rst_r;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("bad reset value");

	property p_reverse;
		@(posedge mclk) disable iff (!nrst)
		rd_hit |=> rdata_r[7] == $past(cnt_r[0]) && rdata_r[2] == $past(cnt_r[5]);
	endproperty
	a_reverse: assert property (p_reverse)
		else $error("count bits not reversed");

	property p_free_timer;
		@(posedge mclk) disable iff (!nrst)
		!active && step && !wr_hit && !sys_rst_r |=> !sys_rst_r;
	endproperty
	a_free_timer: assert property (p_free_timer)
		else $error("inactive timer caused reset");

	property p_rd_idle;
		@(posedge mclk) disable iff (!nrst)
		!rd_hit |=> (rdata_r == 8'h00);
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not cleared");

	property p_wait_enter;
		@(posedge mclk) disable iff (!nrst)
		(pm_r == PM_RUN) && wait_req && !stop_req |=> cpu_wait_r;
	endproperty
	a_wait_enter: assert property (p_wait_enter)
		else $error("wait request not taken");

	property p_wake;
		@(posedge mclk) disable iff (!nrst)
		(pm_r != PM_RUN) && wake_irq |=> !osc_halt_r && !cpu_wait_r;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake did not return to run");

endmodule : wdt_core

/* design/wdt_params.svh */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// Register map
`define WDT_REG_ADDR      8'hD8
`define WDT_REG_RESET     8'hFE
`define WDT_BIT_ACTIVATE  0
`define WDT_BIT_SOFT_RST  1
`define WDT_CNT_LO_BIT    2
`define WDT_CNT_HI_BIT    7

// Counter values
`define WDT_CNT_RESET     7'h7F
`define WDT_CNT_EDGE      7'h40

// Timing
`define WDT_CLK_DIV       12
`define WDT_STEP_TICKS    256
`define WDT_STEP_CYCLES   (`WDT_CLK_DIV * `WDT_STEP_TICKS)
`define WDT_MIN_PERIOD    3072
`define WDT_MAX_PERIOD    196608

`endif

/* design/wdt_pkg.sv */
package wdt_pkg;

	typedef enum logic [1:0] {
		PM_RUN  = 2'b00,
		PM_WAIT = 2'b01,
		PM_STOP = 2'b10
	} pmode_t;

	typedef logic [6:0] wdt_cnt_t;

endpackage : wdt_pkg

/* design/wdt_prescaler.sv */
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_prescaler #(
	parameter int DIV   = `WDT_CLK_DIV,
	parameter int TICKS = `WDT_STEP_TICKS
) (
	input  wire logic mclk,
	input  wire logic nrst,
	wdt_tick_if.src   tk
);
	logic [3:0] div_r;
	logic [7:0] tick_r;
	logic       wd_clk_en;

	assign wd_clk_en = tk.run && (div_r == 4'(DIV - 1));

	// Internal clock divided by twelve
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_r <= 4'h0;
		end else if (tk.run) begin
			div_r <= wd_clk_en ? 4'h0 : div_r + 4'h1;
		end
	end

	// One count step per 256 watchdog clocks
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tick_r  <= 8'h00;
			tk.step <= 1'b0;
		end else begin
			tk.step <= 1'b0;
			if (wd_clk_en) begin
				tick_r <= (tick_r == 8'(TICKS - 1)) ? 8'h00 : tick_r + 8'h01;
				tk.step <= (tick_r == 8'(TICKS - 1));
			end
		end
	end

	property p_step_gap;
		@(posedge mclk) disable iff (!nrst)
		tk.step |=> !tk.step [*8];
	endproperty
	a_step_gap: assert property (p_step_gap)
		else $error("count steps too close");

endmodule : wdt_prescaler

/* design/wdt_tick_if.sv */
`timescale 1ns/1ps

interface wdt_tick_if;
	logic run;
	logic step;

	modport ctrl (output run, input step);
	modport src  (input run, output step);
endinterface : wdt_tick_if

/* tb/digital_watchdog_timer_bench.sv */
`timescale 1ns/1ps

module digital_watchdog_timer_bench;
	import wdt_pkg::*;

	logic       mclk = 0, nrst = 0, hw_option = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic       wr_en = 0, rd_en = 0, stop_req = 0, wait_req = 0;
	logic       wake_irq = 0;
	logic [7:0] rdata_r;
	logic       sys_rst_r, osc_halt_r, cpu_wait_r;
	int         n_mismatch = 0, checks = 0, cyc = 0, seed = 80558;
	logic [7:0] w;

	wdt_core u_dut (.mclk(mclk), .nrst(nrst), .hw_option(hw_option),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.stop_req(stop_req), .wait_req(wait_req), .wake_irq(wake_irq),
		.rdata_r(rdata_r), .sys_rst_r(sys_rst_r),
		.osc_halt_r(osc_halt_r), .cpu_wait_r(cpu_wait_r));

	always #10 mclk = ~mclk;

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic do_reset(logic hw);
		nrst = 0;
		hw_option = hw;
		tick(20);
		nrst = 1;
	endtask : do_reset

	task automatic wr(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1;
		tick(1);
		wr_en = 0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
		addr = a;
		rd_en = 1;
		tick(1);
		rd_en = 0;
		chk(nm, rdata_r, exp);
	endtask : rd

	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask : pulse

	// Model: counter value from a register image, bits reversed
	function automatic int cnt_of(logic [7:0] d);
		int c;
		c = d[1] ? 64 : 0;
		for (int i = 0; i < 6; i++)
			if (d[7-i])
				c += 1 << i;
		return c;
	endfunction : cnt_of

	// Reset must land inside the step window derived from the count
	task automatic expect_expiry(logic [7:0] d);
		int n, k;
		n = cnt_of(d) - 63;
		k = 0;
		while (sys_rst_r !== 1'b1 && k < n * 3072 + 2) begin
			tick(1);
			k++;
		end
		chk("expiry", {7'h00, k > (n - 1) * 3072}, 8'h01);
		chk("rst_out", {7'h00, sys_rst_r}, 8'h01);
	endtask : expect_expiry

	////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(0);
		rd(8'hD8, 8'hFE, "reset_val");
		for (int i = 0; i < 4; i++) begin
			w = 8'(($random(seed) & 8'hFC) | 8'h02);
			wr(8'hD8, w);
			rd(8'hD8, w, "readback");
		end
		wr(8'hD9, 8'h00);
		rd(8'hD9, 8'h00, "unmapped");
		pulse(stop_req);
		chk("halt", {7'h00, osc_halt_r}, 8'h01);
		wr(8'hD8, 8'hFE);
		tick(3100);
		rd(8'hD8, 8'hFE, "frozen");
		pulse(wake_irq);
		chk("resume", {7'h00, osc_halt_r}, 8'h00);
		wr(8'hD8, 8'h82);
		tick(7000);
		chk("free_run", {7'h00, sys_rst_r}, 8'h00);
		wr(8'hD8, 8'h83);
		tick(1);
		wr(8'hD8, 8'h82);
		expect_expiry(8'h82);
		do_reset(0);
		chk("rst_clear", {7'h00, sys_rst_r}, 8'h00);
		wr(8'hD8, 8'h80);
		tick(1);
		chk("soft_rst", {7'h00, sys_rst_r}, 8'h01);
		do_reset(1);
		rd(8'hD8, 8'hFF, "hw_val");
		pulse(stop_req);
		chk("hw_halt", {7'h00, osc_halt_r}, 8'h00);
		chk("hw_wait", {7'h00, cpu_wait_r}, 8'h01);
		pulse(wake_irq);
		chk("hw_woke", {7'h00, cpu_wait_r}, 8'h00);
		pulse(wait_req);
		chk("wait", {7'h00, cpu_wait_r}, 8'h01);
		pulse(wake_irq);
		for (int i = 0; i < 3; i++) begin
			wr(8'hD8, 8'h82);
			tick(3000);
		end
		chk("reload", {7'h00, sys_rst_r}, 8'h00);
		wr(8'hD8, 8'hC2);
		expect_expiry(8'hC2);
		close_out();
	end
endmodule : digital_watchdog_timer_bench
